// [rtl/albkt_map.svh]
// register indices, field positions, reset values and timing counts
// assumes a 100 MHz system clock; byte address is four times the index
`ifndef ALBKT_MAP_SVH
`define ALBKT_MAP_SVH

// register indices (byte address = index * 4)
`define ALB_IDX_CAPACITY 8'h56
`define ALB_IDX_LEAK 8'h57
`define ALB_IDX_CLEAR_LVL 8'h60
`define ALB_IDX_SET_LVL 8'h61
`define ALB_IDX_STATUS 8'h62
`define ALB_IDX_MASK 8'h63
`define ALB_IDX_LEVEL 8'h64

// reset values
`define ALB_RST_CAPACITY 8'h08
`define ALB_RST_LEAK 2'h1
`define ALB_RST_CLEAR_LVL 8'h00
`define ALB_RST_SET_LVL 8'h06
`define ALB_RST_MASK 3'h0

// status and mask bit positions
`define ALB_ST_RAISED 0
`define ALB_ST_CLEARED 1
`define ALB_ST_FULL 2
`define ALB_ST_WIDTH 3

// level register field: alarm flag position
`define ALB_LVL_ALARM 8

// timing: evaluation cycle and clock period
`define ALB_CYCLE_MS 128
`define ALB_CLK_PERIOD_NS 10
`define ALB_CYCLE_CLKS (`ALB_CYCLE_MS * 1000000 / `ALB_CLK_PERIOD_NS)

`endif

// [rtl/albkt_pkg.sv]
// types shared by the leaky bucket activity monitor
// assumes the map header carries all numeric constants
package albkt_pkg;

  // software configuration of one bucket
  typedef struct packed {
    logic [7:0] capacity;
    logic [7:0] clear_lvl;
    logic [7:0] set_lvl;
    logic [1:0] leak_rate;
  } albkt_cfg_type;

  // inactivity alarm state
  typedef enum logic {
    ALB_QUIET,
    ALB_ALARMED
  } albkt_alarm_type;

endpackage

// [rtl/albkt_tick.sv]
// evaluation cycle timer: one-cycle pulse every cycle_clks clocks
// assumes hclk runs freely; hresetn asynchronous, active low
module albkt_tick #(
  parameter int unsigned CYCLE_CLKS = 12800000
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // evaluation tick
  output logic tick
);

  logic [23:0] cnt_q;

  // free-running divider; the pulse is taken at the last count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 24'h000000;
    else if (cnt_q == 24'(CYCLE_CLKS - 1))
      cnt_q <= 24'h000000;
    else
      cnt_q <= cnt_q + 24'h000001;
  end

  assign tick = (cnt_q == 24'(CYCLE_CLKS - 1));

endmodule

// [rtl/albkt_top.sv]
// leaky bucket activity monitor for one watched clock input
// assumes an ahb-lite master, fail/erratic flags synchronous to hclk
//
// Behaviour
// - accumulator changes only on the 128 ms evaluation tick.
// - a cycle with a failure or erratic event adds one.
// - each quiet run of 1, 2, 4 or 8 cycles subtracts one.
// - the 8-bit capacity caps the accumulator; it never counts past it.
// - reaching the lower level clears the inactivity alarm.
// - leak code 00..11 means 128/256/512/1024 ms; reset code is 01.
//
// Local design decision: the AHB-Lite slave port.
`include "albkt_map.svh"

module albkt_top #(
  parameter int unsigned CYCLE_CLKS = `ALB_CYCLE_CLKS
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // watched input status
  input wire logic input_failed,
  input wire logic input_erratic,
  // alarm and interrupt
  output logic alarm,
  output logic irq
);

  albkt_pkg::albkt_cfg_type cfg_q;
  albkt_pkg::albkt_alarm_type alarm_q;
  logic [7:0] acc_q;
  logic [2:0] run_q;
  logic hit_seen_q;
  logic [`ALB_ST_WIDTH-1:0] status_q;
  logic [`ALB_ST_WIDTH-1:0] mask_q;
  logic [`ALB_ST_WIDTH-1:0] set_ev;
  logic wr_q;
  logic rd_q;
  logic [7:0] idx_q;
  logic tick;
  logic hit;
  logic run_end;
  logic full_hit;
  logic [2:0] run_last;

  // evaluation cycle timer
  albkt_tick #(
    .CYCLE_CLKS(CYCLE_CLKS)
  )
  u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  // ---------------- bus slave ----------------
  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // capture the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      rd_q <= hsel && htrans[1] && !hwrite;
      idx_q <= haddr[9:2];
    end
  end

  // configuration writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q.capacity <= `ALB_RST_CAPACITY;
      cfg_q.clear_lvl <= `ALB_RST_CLEAR_LVL;
      cfg_q.set_lvl <= `ALB_RST_SET_LVL;
      cfg_q.leak_rate <= `ALB_RST_LEAK;
      mask_q <= `ALB_RST_MASK;
    end
    else if (wr_q)
    begin
      case (idx_q)
        `ALB_IDX_CAPACITY: cfg_q.capacity <= hwdata[7:0];
        `ALB_IDX_LEAK: cfg_q.leak_rate <= hwdata[1:0];
        `ALB_IDX_CLEAR_LVL: cfg_q.clear_lvl <= hwdata[7:0];
        `ALB_IDX_SET_LVL: cfg_q.set_lvl <= hwdata[7:0];
        `ALB_IDX_MASK: mask_q <= hwdata[`ALB_ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // read mux over flip-flops; unmapped indices read zero
  always_comb
  begin
    hrdata = 32'h00000000;
    if (rd_q)
    begin
      case (idx_q)
        `ALB_IDX_CAPACITY: hrdata[7:0] = cfg_q.capacity;
        `ALB_IDX_LEAK: hrdata[1:0] = cfg_q.leak_rate;
        `ALB_IDX_CLEAR_LVL: hrdata[7:0] = cfg_q.clear_lvl;
        `ALB_IDX_SET_LVL: hrdata[7:0] = cfg_q.set_lvl;
        `ALB_IDX_STATUS: hrdata[`ALB_ST_WIDTH-1:0] = status_q;
        `ALB_IDX_MASK: hrdata[`ALB_ST_WIDTH-1:0] = mask_q;
        `ALB_IDX_LEVEL:
        begin
          hrdata[7:0] = acc_q;
          hrdata[`ALB_LVL_ALARM] = (alarm_q == albkt_pkg::ALB_ALARMED);
        end
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  // ---------------- bucket ----------------
  // a short glitch anywhere in the cycle still counts as a hit
  assign hit = hit_seen_q || input_failed || input_erratic;

  // quiet run length minus one: 0, 1, 3 or 7 cycles
  assign run_last = 3'((4'h1 << cfg_q.leak_rate) - 4'h1);
  assign run_end = (run_q == run_last);
  assign full_hit = tick && hit && (acc_q >= cfg_q.capacity);

  // hit memory for the running evaluation cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hit_seen_q <= 1'b0;
    else if (tick)
      hit_seen_q <= 1'b0;
    else if (input_failed || input_erratic)
      hit_seen_q <= 1'b1;
  end

  // quiet run counter, restarted by any hit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_q <= 3'h0;
    else if (tick)
    begin
      if (hit || run_end)
        run_q <= 3'h0;
      else
        run_q <= run_q + 3'h1;
    end
  end

  // accumulator: fill, saturate, leak; touched only on the tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_q <= 8'h00;
    else if (tick)
    begin
      if (hit)
      begin
        if (acc_q < cfg_q.capacity)
          acc_q <= acc_q + 8'h01;
        else
          acc_q <= cfg_q.capacity;
      end
      else if (run_end && acc_q != 8'h00)
        acc_q <= acc_q - 8'h01;
    end
  end

  // alarm with hysteresis; set wins if the levels are crossed over
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alarm_q <= albkt_pkg::ALB_QUIET;
    else
    begin
      case (alarm_q)
        albkt_pkg::ALB_QUIET:
          if (acc_q >= cfg_q.set_lvl)
            alarm_q <= albkt_pkg::ALB_ALARMED;
        albkt_pkg::ALB_ALARMED:
          if (acc_q <= cfg_q.clear_lvl && acc_q < cfg_q.set_lvl)
            alarm_q <= albkt_pkg::ALB_QUIET;
        default: alarm_q <= albkt_pkg::ALB_QUIET;
      endcase
    end
  end

  assign alarm = (alarm_q == albkt_pkg::ALB_ALARMED);

  // ---------------- interrupts ----------------
  always_comb
  begin
    set_ev = '0;
    set_ev[`ALB_ST_RAISED] = (alarm_q == albkt_pkg::ALB_QUIET) &&
      (acc_q >= cfg_q.set_lvl);
    set_ev[`ALB_ST_CLEARED] = (alarm_q == albkt_pkg::ALB_ALARMED) &&
      (acc_q <= cfg_q.clear_lvl) && (acc_q < cfg_q.set_lvl);
    set_ev[`ALB_ST_FULL] = full_hit;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_q <= '0;
    else if (wr_q && idx_q == `ALB_IDX_STATUS)
      status_q <= (status_q & ~hwdata[`ALB_ST_WIDTH-1:0]) | set_ev;
    else
      status_q <= status_q | set_ev;
  end

  assign irq = |(status_q & mask_q);

  // ---------------- checks ----------------
  a_acc_tick_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !tick |=> $stable(acc_q))
    else $error("accumulator moved without an evaluation tick");

  a_fill_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && hit && acc_q < cfg_q.capacity |=> acc_q == $past(acc_q) + 8'h01)
    else $error("hit cycle did not add one");

  a_leak_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && !hit && run_end && acc_q != 8'h00
      |=> acc_q == $past(acc_q) - 8'h01)
    else $error("quiet run did not subtract one");

  a_cap_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && hit && acc_q >= cfg_q.capacity |=> acc_q == $past(cfg_q.capacity))
    else $error("accumulator passed its capacity");

  a_leak_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && !hit && cfg_q.leak_rate == 2'h3 && run_q == 3'h6
      |=> $stable(acc_q) && run_q == 3'h7)
    else $error("slowest leak code subtracted early");

  a_alarm_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    alarm && acc_q <= cfg_q.clear_lvl && acc_q < cfg_q.set_lvl
      |=> !alarm ##0 status_q[`ALB_ST_CLEARED])
    else $error("alarm not cleared at lower level");

  a_alarm_raise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc_q >= cfg_q.set_lvl |=> alarm)
    else $error("alarm not raised at upper level");

  a_alarm_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    alarm && acc_q > cfg_q.clear_lvl |=> alarm)
    else $error("alarm dropped above lower level");

  // a hit on a full bucket must leave a trace for software
  a_full_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    full_hit |=> status_q[`ALB_ST_FULL])
    else $error("hit on a full bucket not flagged");

  // only a status clear or a mask change may drop the interrupt
  a_irq_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq && !(wr_q && (idx_q == `ALB_IDX_STATUS || idx_q == `ALB_IDX_MASK))
      |=> irq)
    else $error("interrupt dropped without a clear or mask write");

  a_quiet_restart: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && hit |=> run_q == 3'h0)
    else $error("hit did not restart the quiet run");

  // the bucket must not wrap below empty on a leak
  a_leak_floor: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tick && !hit && acc_q == 8'h00 |=> acc_q == 8'h00)
    else $error("empty bucket leaked below zero");

  a_raise_status: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(alarm) |-> status_q[`ALB_ST_RAISED])
    else $error("alarm raised without its status bit");

endmodule

// [test/albkt_src_model.sv]
// partner model: failure and erratic flags of the watched clock input
// assumes the bench asks for one-cycle events just after a rising edge
module albkt_src_model
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // event request from the bench
  input wire logic go,
  input wire logic kind,
  // flags seen by the monitor
  output logic failed,
  output logic erratic
);
  timeunit 1ns;
  timeprecision 1ps;
  // one-cycle event; both kinds must count alike, so mix them
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      failed <= 1'b0;
      erratic <= 1'b0;
    end
    else
    begin
      failed <= go & ~kind;
      erratic <= go & kind;
    end
endmodule

// [test/tb.sv]
// self-checking bench for the leaky bucket monitor, integer model inside
// assumes a short evaluation cycle of 64 clocks set through CYCLE_CLKS
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int C = 64;
  logic hclk, hresetn, hsel, hwrite, hready, go, kind;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, failed, erratic, alarm, irq;
  int n_mismatch, checks_done, cyc, acc, run, cap, leak, setl, clrl, al, st;
  int msk;
  albkt_top #(.CYCLE_CLKS(C)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .input_failed(failed), .input_erratic(erratic), .alarm(alarm),
    .irq(irq));
  albkt_src_model i_src (.hclk(hclk), .hresetn(hresetn), .go(go),
    .kind(kind), .failed(failed), .erratic(erratic));
  assign hready = hreadyout;
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // phase counter restarts with reset, as the tick timer does
  always @(posedge hclk or negedge hresetn)
    cyc <= !hresetn ? 0 : cyc + 1;
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single ahb transfer; each phase stands until hready is seen high
  task automatic bus(input logic w, input logic [7:0] idx,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk);
    while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk);
    while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_ph(input int ph);
    hsel <= 1'b0;
    do @(negedge hclk);
    while (cyc % C != ph);
    @(posedge hclk);
  endtask
  // alarm hysteresis as seen by software, applied after every change
  task automatic lvl_model();
    if (acc >= setl)
    begin
      if (al == 0) st |= 1;
      al = 1;
    end
    else if (acc <= clrl && al != 0)
    begin
      al = 0;
      st |= 2;
    end
  endtask
  // one evaluation cycle: event at phase 20 of the window, checks after the tick
  task automatic eval_cycle(input bit hit);
    wait_ph(20);
    go <= hit;
    kind <= 1'($urandom);
    @(posedge hclk);
    go <= 1'b0;
    if (hit)
    begin
      if (acc >= cap) st |= 4;
      acc = (acc + 1 > cap) ? cap : acc + 1;
      run = 0;
    end
    else if (++run >= (1 << leak))
    begin
      run = 0;
      if (acc > 0) acc--;
    end
    lvl_model();
    wait_ph(1);
    bus(1'b0, 8'h64, 32'h0);
    chk("level", {23'h0, al[0], acc[7:0]}, rd);
    chk("alarm", 32'(al), {31'h0, alarm});
    bus(1'b0, 8'h62, 32'h0);
    chk("status", 32'(st), rd & 32'h7);
    chk("irq", 32'((st & msk) != 0), {31'h0, irq});
    bus(1'b1, 8'h62, 32'h7);
    st = 0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    $display("timeout waiting for the bench");
    finish_test();
  end
  initial
  begin
    logic [7:0] ridx [8];
    logic [31:0] rexp [8];
    ridx = '{8'h56, 8'h57, 8'h60, 8'h61, 8'h63, 8'h65, 8'h62, 8'h64};
    rexp = '{32'h8, 32'h1, 32'h0, 32'h6, 32'h0, 32'h0, 32'h0, 32'h0};
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, go, kind} = '0;
    hsize = 3'h2;
    {n_mismatch, checks_done, acc, run, al, st, clrl} = '0;
    cap = 8;
    leak = 1;
    setl = 6;
    msk = 3;
    void'($urandom(32'ha0ef));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values plus one unmapped index, all inside the first window
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, ridx[i], 32'h0);
      chk("reset value", rexp[i], rd);
    end
    bus(1'b1, 8'h63, 32'h3);
    $display("test reset values done");
    repeat (12) eval_cycle(1'b1);
    repeat (20) eval_cycle(1'b0);
    $display("test fill and drain done");
    // every leak code, random capacity and levels, random events
    for (int k = 0; k < 4; k++)
    begin
      eval_cycle(1'b1);
      cap = 4 + $urandom % 12;
      leak = k;
      msk = $urandom % 8;
      bus(1'b1, 8'h56, cap);
      bus(1'b1, 8'h57, leak);
      bus(1'b1, 8'h63, msk);
      // levels act within a cycle, so the model follows each write
      setl = 1 + $urandom % cap;
      bus(1'b1, 8'h61, setl);
      lvl_model();
      clrl = $urandom % setl;
      bus(1'b1, 8'h60, clrl);
      lvl_model();
      repeat (24) eval_cycle($urandom % 3 != 0);
      repeat (10) eval_cycle(1'b0);
      $display("test leak code %0d done", k);
    end
    finish_test();
  end
endmodule
